// ==== hdl/literal_table_branch_call_decoder.sv ====
`timescale 1ns/1ps
// Function
// RL1 - add immediate updates all five flags
// RL2 - and immediate, only zero and negative
// RL3 - or immediate, only zero and negative
// RL4 - xor immediate, only zero and negative
// RL5 - immediate minus accumulator, all five flags
// RL6 - load accumulator immediate, flags unchanged
// RL7 - multiply immediate into product, flags unchanged
// RL8 - four-bit immediate into bank select
// RL9 - return with immediate, two cycles
// RL10 - two-word twelve-bit pointer load
// RL11 - table reads, four pointer modes, two cycles
// RL12 - table writes, four pointer modes, two cycles
// RL13 - started memory write continues until terminated
// RL14 - port self-modify reads pins, not latch
// RL15 - timer count write clears assigned prescaler
// RL16 - taken flow change adds a no-op cycle
// RL17 - stray second word executes as no-op
// RL18 - branch on zero to PC+2+2n
// RL19 - call pushes address plus four, loads target
// RL20 - fast call bit saves into shadows
// RL21 - 21-bit table pointer, 8-bit table latch
// RL22 - flushed fetch has no side effect
module literal_table_branch_call_decoder
    import literal_decoder_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic [15:0]                 instr_word,
    input  wire logic [20:0]                 return_stack_top,
    input  wire logic [7:0]                  pm_rdata,
    input  wire logic                        pm_write_arm,
    input  wire logic                        pm_write_done,
    input  wire logic                        timer_zero_write,
    input  wire logic                        prescaler_assigned,
    input  wire logic                        port_target,
    input  wire logic [7:0]                  port_pins,
    input  wire logic [7:0]                  port_latch,
    output logic [20:0]                      fetch_addr,
    output logic [7:0]                       working_accumulator,
    output logic [literal_decoder_pkg::FLAG_COUNT-1:0] status_flags,
    output logic [3:0]                       bank_select_register,
    output logic [15:0]                      product,
    output logic [literal_decoder_pkg::PTR_COUNT*12-1:0] indirect_pointer,
    output logic [20:0]                      program_memory_pointer,
    output logic [7:0]                       program_memory_latch,
    output logic [7:0]                       accumulator_shadow,
    output logic [literal_decoder_pkg::FLAG_COUNT-1:0] flags_shadow,
    output logic [3:0]                       bank_shadow,
    output logic                             stack_push,
    output logic [20:0]                      stack_push_addr,
    output logic                             stack_pop,
    output logic                             pm_read,
    output logic                             pm_write,
    output logic [20:0]                      pm_addr,
    output logic [7:0]                       pm_wdata,
    output logic                             pm_write_active,
    output logic                             prescaler_clear,
    output logic [7:0]                       rmw_source
);

    typedef struct packed {
        exec_state_t                  st;
        logic [7:0]                   acc;
        logic [FLAG_COUNT-1:0]        flags;
        logic [3:0]                   bank;
        logic [15:0]                  prod;
        logic [PTR_COUNT-1:0][11:0]   ptr;
        logic [20:0]                  mptr;
        logic [7:0]                   mlat;
        logic [7:0]                   acc_sh;
        logic [FLAG_COUNT-1:0]        flags_sh;
        logic [3:0]                   bank_sh;
        logic [20:0]                  pc;
        logic                         is_call;
        logic [1:0]                   sel;
        logic [7:0]                   held;
        logic                         tbl_wr;
        logic [1:0]                   tbl_mode;
        logic [20:0]                  mem_addr;
        logic                         mem_rd;
        logic                         mem_wr;
        logic                         wr_active;
        logic                         push;
        logic [20:0]                  push_addr;
        logic                         pop;
        logic                         pre_clr;
    } core_t;

    core_t s_q;
    core_t s_d;

    logic [7:0] imm;
    logic [8:0] add_sum;
    logic [4:0] add_nib;
    logic [8:0] sub_sum;
    logic [4:0] sub_nib;
    logic [7:0] logic_res;
    logic [20:0] branch_target;

    assign imm           = instr_word[7:0];
    assign add_sum       = {1'b0, s_q.acc} + {1'b0, imm};
    assign add_nib       = {1'b0, s_q.acc[3:0]} + {1'b0, imm[3:0]};
    assign sub_sum       = {1'b0, imm} + {1'b0, ~s_q.acc} + 9'h001;
    assign sub_nib       = {1'b0, imm[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
    assign branch_target = s_q.pc + PC_STEP + {{12{imm[7]}}, imm, 1'b0};

    always_comb begin
        logic_res = 8'h00;
        unique case (instr_word[15:8])
            OP_AND_IMMEDIATE: logic_res = s_q.acc & imm;
            OP_OR_IMMEDIATE:  logic_res = s_q.acc | imm;
            default:          logic_res = s_q.acc ^ imm;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_d         = s_q;
        s_d.mem_rd  = 1'b0;
        s_d.mem_wr  = 1'b0;
        s_d.push    = 1'b0;
        s_d.pop     = 1'b0;
        s_d.pre_clr = timer_zero_write && prescaler_assigned; // see RL15
        // A write that has started keeps running; a new start wins over done.
        if (s_q.mem_wr && pm_write_arm) begin
            s_d.wr_active = 1'b1; // see RL13
        end else if (pm_write_done) begin
            s_d.wr_active = 1'b0; // see RL13
        end
        unique case (s_q.st)
            ST_EXEC: begin
                s_d.pc = s_q.pc + PC_STEP; // see RL17
                if (instr_word[15:8] == OP_ADD_IMMEDIATE) begin
                    s_d.acc                = add_sum[7:0]; // see RL1
                    s_d.flags[FLAG_CARRY]  = add_sum[8];
                    s_d.flags[FLAG_DIGIT]  = add_nib[4];
                    s_d.flags[FLAG_ZERO]   = (add_sum[7:0] == 8'h00);
                    s_d.flags[FLAG_OVF]    = (s_q.acc[7] == imm[7]) && (add_sum[7] != imm[7]);
                    s_d.flags[FLAG_NEG]    = add_sum[7];
                end else if (instr_word[15:8] == OP_REVERSE_SUBTRACT) begin
                    s_d.acc                = sub_sum[7:0]; // see RL5
                    s_d.flags[FLAG_CARRY]  = sub_sum[8];
                    s_d.flags[FLAG_DIGIT]  = sub_nib[4];
                    s_d.flags[FLAG_ZERO]   = (sub_sum[7:0] == 8'h00);
                    s_d.flags[FLAG_OVF]    = (s_q.acc[7] != imm[7]) && (sub_sum[7] != imm[7]);
                    s_d.flags[FLAG_NEG]    = sub_sum[7];
                end else if (instr_word[15:8] == OP_AND_IMMEDIATE
                             || instr_word[15:8] == OP_OR_IMMEDIATE
                             || instr_word[15:8] == OP_XOR_IMMEDIATE) begin
                    s_d.acc               = logic_res; // see RL2 see RL3 see RL4
                    s_d.flags[FLAG_ZERO]  = (logic_res == 8'h00);
                    s_d.flags[FLAG_NEG]   = logic_res[7];
                end else if (instr_word[15:8] == OP_LOAD_ACCUMULATOR) begin
                    s_d.acc = imm; // see RL6
                end else if (instr_word[15:8] == OP_MULTIPLY_IMMEDIATE) begin
                    s_d.prod = s_q.acc * imm; // see RL7
                end else if (instr_word[15:4] == OP_SET_BANK_IMMEDIATE) begin
                    s_d.bank = instr_word[3:0]; // see RL8
                end else if (instr_word[15:8] == OP_RETURN_WITH_IMM) begin
                    s_d.acc = imm; // see RL9
                    s_d.pc  = return_stack_top;
                    s_d.pop = 1'b1;
                    s_d.st  = ST_FLUSH; // see RL16
                end else if (instr_word[15:8] == OP_BRANCH_ON_ZERO_FLAG) begin
                    if (s_q.flags[FLAG_ZERO]) begin
                        s_d.pc = branch_target; // see RL18
                        s_d.st = ST_FLUSH; // see RL16
                    end
                end else if (instr_word[15:6] == OP_LOAD_POINTER_FIRST) begin
                    s_d.is_call = 1'b0; // see RL10
                    s_d.sel     = instr_word[5:4];
                    s_d.held    = {4'h0, instr_word[3:0]};
                    s_d.st      = ST_SECOND;
                end else if (instr_word[15:9] == OP_CALL_FIRST) begin
                    s_d.is_call   = 1'b1;
                    s_d.held      = imm;
                    s_d.push      = 1'b1; // see RL19
                    s_d.push_addr = s_q.pc + PC_STEP_TWO;
                    if (instr_word[8]) begin
                        s_d.acc_sh   = s_q.acc; // see RL20
                        s_d.flags_sh = s_q.flags;
                        s_d.bank_sh  = s_q.bank;
                    end
                    s_d.st = ST_SECOND;
                end else if (instr_word[15:2] == OP_PROGRAM_MEMORY_READ
                             || instr_word[15:2] == OP_PROGRAM_MEMORY_WRITE) begin
                    s_d.tbl_wr   = instr_word[2]; // see RL11 see RL12
                    s_d.tbl_mode = instr_word[1:0];
                    s_d.mem_addr = (instr_word[1:0] == TBL_PRE_INC)
                                 ? s_q.mptr + TBL_STEP : s_q.mptr; // see RL21
                    s_d.mem_rd   = !instr_word[2];
                    s_d.mem_wr   = instr_word[2];
                    unique case (instr_word[1:0])
                        TBL_KEEP:     s_d.mptr = s_q.mptr;
                        TBL_POST_DEC: s_d.mptr = s_q.mptr - TBL_STEP;
                        TBL_POST_INC,
                        TBL_PRE_INC:  s_d.mptr = s_q.mptr + TBL_STEP;
                    endcase
                    s_d.st = ST_TABLE;
                end
                // A stray second word and every other code only advance the PC by PC_STEP.
            end
            ST_SECOND: begin
                if (s_q.is_call) begin
                    s_d.pc = {instr_word[11:0], s_q.held, 1'b0}; // see RL19
                end else begin
                    s_d.pc = s_q.pc + PC_STEP;
                    if (instr_word[15:8] == OP_LOAD_POINTER_SECOND && s_q.sel != 2'h3) begin
                        s_d.ptr[s_q.sel] = {s_q.held[3:0], imm}; // see RL10
                    end
                end
                s_d.st = ST_EXEC;
            end
            ST_TABLE: begin
                if (!s_q.tbl_wr) begin
                    s_d.mlat = pm_rdata; // see RL11
                end
                s_d.st = ST_EXEC; // see RL12
            end
            ST_FLUSH: begin
                s_d.st = ST_EXEC; // see RL22
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q       <= '0;
            s_q.st    <= ST_EXEC;
            s_q.acc   <= ACC_RESET;
            s_q.flags <= FLAGS_RESET;
            s_q.bank  <= BANK_RESET;
            s_q.pc    <= PC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign fetch_addr             = s_q.pc;
    assign working_accumulator    = s_q.acc;
    assign status_flags           = s_q.flags;
    assign bank_select_register   = s_q.bank;
    assign product                = s_q.prod;
    assign indirect_pointer       = s_q.ptr;
    assign program_memory_pointer = s_q.mptr;
    assign program_memory_latch   = s_q.mlat;
    assign accumulator_shadow     = s_q.acc_sh;
    assign flags_shadow           = s_q.flags_sh;
    assign bank_shadow            = s_q.bank_sh;
    assign stack_push             = s_q.push;
    assign stack_push_addr        = s_q.push_addr;
    assign stack_pop              = s_q.pop;
    assign pm_read                = s_q.mem_rd;
    assign pm_write               = s_q.mem_wr;
    assign pm_addr                = s_q.mem_addr;
    assign pm_wdata               = s_q.mlat;
    assign pm_write_active        = s_q.wr_active || (s_q.mem_wr && pm_write_arm);
    assign prescaler_clear        = s_q.pre_clr;
    assign rmw_source             = port_target ? port_pins : port_latch; // see RL14

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    logic in_exec;
    assign in_exec = (s_q.st == ST_EXEC);

    sequence call_first_seen;
        in_exec && instr_word[15:9] == OP_CALL_FIRST;
    endsequence

    sequence call_second_taken;
        ##1 (s_q.st == ST_SECOND && stack_push) ##1 (s_q.st == ST_EXEC);
    endsequence

    a_add_result: assert property (in_exec && instr_word[15:8] == OP_ADD_IMMEDIATE |=> // see RL1
        working_accumulator == 8'($past(s_q.acc) + $past(imm)))
        else $error("Add immediate result wrong.");

    a_logic_keep_carry: assert property (in_exec // see RL2
        && (instr_word[15:8] == OP_AND_IMMEDIATE || instr_word[15:8] == OP_XOR_IMMEDIATE)
        |=> $stable(status_flags[FLAG_CARRY]) && $stable(status_flags[FLAG_OVF]))
        else $error("Logic immediate touched carry or overflow.");

    a_sub_carry: assert property (in_exec && instr_word[15:8] == OP_REVERSE_SUBTRACT |=> // see RL5
        status_flags[FLAG_CARRY] == ($past(imm) >= $past(s_q.acc)))
        else $error("Reverse subtract carry wrong.");

    a_load_no_flags: assert property (in_exec && instr_word[15:8] == OP_LOAD_ACCUMULATOR // see RL6
        |=> $stable(status_flags) && working_accumulator == $past(imm))
        else $error("Load accumulator wrong or flags changed.");

    a_mul_product: assert property (in_exec && instr_word[15:8] == OP_MULTIPLY_IMMEDIATE // see RL7
        |=> product == $past(s_q.acc) * $past(imm) && $stable(status_flags))
        else $error("Multiply immediate product wrong.");

    a_bank_load: assert property (in_exec && instr_word[15:4] == OP_SET_BANK_IMMEDIATE // see RL8
        |=> bank_select_register == $past(instr_word[3:0]))
        else $error("Bank select not loaded.");

    a_return_flush: assert property (in_exec && instr_word[15:8] == OP_RETURN_WITH_IMM // see RL9
        |=> stack_pop && fetch_addr == $past(return_stack_top) ##1 !stack_pop && in_exec)
        else $error("Return with immediate not two cycles.");

    a_branch_taken: assert property (in_exec // see RL18
        && instr_word[15:8] == OP_BRANCH_ON_ZERO_FLAG && status_flags[FLAG_ZERO]
        |=> fetch_addr == $past(branch_target) && !in_exec)
        else $error("Taken branch target or timing wrong.");

    a_branch_skip: assert property (in_exec // see RL18
        && instr_word[15:8] == OP_BRANCH_ON_ZERO_FLAG && !status_flags[FLAG_ZERO]
        |=> in_exec && fetch_addr == $past(s_q.pc) + PC_STEP)
        else $error("Untaken branch took two cycles.");

    a_call_sequence: assert property (call_first_seen |-> call_second_taken) // see RL19
        else $error("Call did not push and finish in two cycles.");

    a_table_strobe: assert property (in_exec // see RL11
        && instr_word[15:2] == OP_PROGRAM_MEMORY_READ
        |=> pm_read && s_q.st == ST_TABLE ##1 !pm_read && in_exec)
        else $error("Table read strobe or length wrong.");

    a_write_holds: assert property (pm_write_active && !pm_write_done // see RL13
        |=> pm_write_active)
        else $error("Memory write ended before termination.");

    a_stray_second: assert property (in_exec // see RL17
        && instr_word[15:12] == OP_SECOND_WORD_NIBBLE |=> $stable(working_accumulator)
        && $stable(status_flags) && $stable(indirect_pointer) && in_exec)
        else $error("Stray second word had an effect.");

    a_flush_quiet: assert property (s_q.st == ST_FLUSH |=> $stable(working_accumulator) // see RL22
        && $stable(status_flags) && $stable(program_memory_pointer) && !stack_push)
        else $error("Flushed fetch caused a side effect.");

    a_prescaler_clear: assert property (timer_zero_write && prescaler_assigned // see RL15
        |=> prescaler_clear ##1 (prescaler_clear == $past(timer_zero_write && prescaler_assigned)))
        else $error("Prescaler clear missing.");

endmodule : literal_table_branch_call_decoder

// ==== hdl/literal_decoder_pkg.sv ====
package literal_decoder_pkg;

    // Opcode fields matched against the upper bits of the instruction word.
    localparam logic [7:0] OP_ADD_IMMEDIATE        = 8'h0F;
    localparam logic [7:0] OP_AND_IMMEDIATE        = 8'h0B;
    localparam logic [7:0] OP_OR_IMMEDIATE         = 8'h09;
    localparam logic [7:0] OP_XOR_IMMEDIATE        = 8'h0A;
    localparam logic [7:0] OP_REVERSE_SUBTRACT     = 8'h08;
    localparam logic [7:0] OP_LOAD_ACCUMULATOR     = 8'h0E;
    localparam logic [7:0] OP_MULTIPLY_IMMEDIATE   = 8'h0D;
    localparam logic [7:0] OP_RETURN_WITH_IMM      = 8'h0C;
    localparam logic [7:0] OP_BRANCH_ON_ZERO_FLAG  = 8'hE0;
    localparam logic [11:0] OP_SET_BANK_IMMEDIATE  = 12'h010;
    localparam logic [9:0] OP_LOAD_POINTER_FIRST   = 10'h3B8;
    localparam logic [7:0] OP_LOAD_POINTER_SECOND  = 8'hF0;
    localparam logic [6:0] OP_CALL_FIRST           = 7'h76;
    localparam logic [13:0] OP_PROGRAM_MEMORY_READ  = 14'h0002;
    localparam logic [13:0] OP_PROGRAM_MEMORY_WRITE = 14'h0003;
    localparam logic [3:0] OP_SECOND_WORD_NIBBLE   = 4'hF;

    // Pointer update modes of the table transfers.
    localparam logic [1:0] TBL_KEEP     = 2'h0;
    localparam logic [1:0] TBL_POST_INC = 2'h1;
    localparam logic [1:0] TBL_POST_DEC = 2'h2;
    localparam logic [1:0] TBL_PRE_INC  = 2'h3;

    // Positions of the flags within the status vector.
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_ZERO  = 2;
    localparam int FLAG_OVF   = 3;
    localparam int FLAG_NEG   = 4;
    localparam int FLAG_COUNT = 5;

    localparam int PC_WIDTH    = 21;
    localparam int PTR_WIDTH   = 12;
    localparam int PTR_COUNT   = 3;

    localparam logic [20:0] PC_STEP     = 21'h000002;
    localparam logic [20:0] PC_STEP_TWO = 21'h000004;
    localparam logic [20:0] TBL_STEP    = 21'h000001;

    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [4:0]  FLAGS_RESET = 5'h00;
    localparam logic [3:0]  BANK_RESET  = 4'h0;
    localparam logic [20:0] PC_RESET    = 21'h000000;

    // Gray order along execute, second word, table cycle, flush.
    typedef enum logic [1:0] {
        ST_EXEC   = 2'h0,
        ST_SECOND = 2'h1,
        ST_TABLE  = 2'h3,
        ST_FLUSH  = 2'h2
    } exec_state_t;

endpackage : literal_decoder_pkg

// ==== sim/prog_mem_model.sv ====
`timescale 1ns/1ps
module prog_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [20:0] fetch_addr,
    input  wire logic        pm_read,
    input  wire logic        pm_write,
    input  wire logic [20:0] pm_addr,
    input  wire logic        arm_en,
    output logic [15:0]      instr_word,
    output logic [7:0]       pm_rdata,
    output logic             pm_write_arm,
    output logic             pm_write_done
);
    logic [15:0] words [256];
    logic [7:0]  spin_q;
    logic [1:0]  wait_q;
    // Outside a read cycle the data keeps moving, so a stale byte is never taken for a hit.
    assign instr_word    = words[fetch_addr[8:1]];
    assign pm_rdata      = pm_read ? (pm_addr[7:0] ^ 8'h5A) : spin_q;
    assign pm_write_arm  = arm_en;
    assign pm_write_done = wait_q == 2'h1;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            spin_q <= 8'h00;
            wait_q <= 2'h0;
        end else begin
            spin_q <= spin_q + 8'h01;
            if (pm_write && arm_en) begin
                wait_q <= 2'h3;
            end else if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule : prog_mem_model

// ==== sim/literal_table_branch_call_decoder_tb.sv ====
`timescale 1ns/1ps
module literal_table_branch_call_decoder_tb;
    import literal_decoder_pkg::*;
    logic        ref_clk = 1'b0, rst_b = 1'b0, arm_en = 1'b0;
    logic        timer_zero_write = 1'b0, prescaler_assigned = 1'b0, port_target = 1'b0;
    logic [7:0]  port_pins = 8'h00, port_latch = 8'h00, pm_rdata;
    logic [20:0] return_stack_top = 21'h000000;
    logic [15:0] instr_word, product, ep;
    logic        pm_write_arm, pm_write_done, stack_push, stack_pop, pm_read, pm_write;
    logic        pm_write_active, prescaler_clear;
    logic [20:0] fetch_addr, program_memory_pointer, stack_push_addr, pm_addr, pc, tp, pa, off;
    logic [7:0]  working_accumulator, program_memory_latch, accumulator_shadow, pm_wdata;
    logic [7:0]  rmw_source, a, k, op, ea, lt;
    logic [4:0]  status_flags, flags_shadow, ef;
    logic [3:0]  bank_select_register, bank_shadow, bk;
    logic [35:0] indirect_pointer, eptr;
    logic [19:0] tgt;
    int          bad_count = 0, check_count = 0, seed = 99506, i;
    logic [7:0]  ops [7] = '{OP_ADD_IMMEDIATE, OP_AND_IMMEDIATE, OP_OR_IMMEDIATE,
        OP_XOR_IMMEDIATE, OP_REVERSE_SUBTRACT, OP_LOAD_ACCUMULATOR, OP_MULTIPLY_IMMEDIATE};

    literal_table_branch_call_decoder dut (.ref_clk, .rst_b, .instr_word, .return_stack_top,
        .pm_rdata, .pm_write_arm, .pm_write_done, .timer_zero_write, .prescaler_assigned,
        .port_target, .port_pins, .port_latch, .fetch_addr, .working_accumulator, .status_flags,
        .bank_select_register, .product, .indirect_pointer, .program_memory_pointer,
        .program_memory_latch, .accumulator_shadow, .flags_shadow, .bank_shadow, .stack_push,
        .stack_push_addr, .stack_pop, .pm_read, .pm_write, .pm_addr, .pm_wdata,
        .pm_write_active, .prescaler_clear, .rmw_source);
    prog_mem_model pmem (.ref_clk, .rst_b, .fetch_addr, .pm_read, .pm_write, .pm_addr, .arm_en,
        .instr_word, .pm_rdata, .pm_write_arm, .pm_write_done);

    always #50 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Places a word at the current fetch address and lets one instruction cycle pass.
    task automatic run(input logic [15:0] w);
        pmem.words[fetch_addr[8:1]] = w;
        @(negedge ref_clk);
    endtask : run

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    function automatic logic [28:0] alu(input logic [7:0] o, x, y, input logic [4:0] f,
                                        input logic [15:0] p);
        logic [8:0] s;
        logic [7:0] r;
        s = x + y;
        r = x;
        case (o)
            OP_ADD_IMMEDIATE: begin
                r = s[7:0];
                f[1:0] = {(x[3:0] + y[3:0]) > 5'h0F, s[8]};
                f[3] = (x[7] == y[7]) && (r[7] != x[7]);
            end
            OP_REVERSE_SUBTRACT: begin
                r = y - x;
                f[1:0] = {y[3:0] >= x[3:0], y >= x};
                f[3] = (x[7] != y[7]) && (r[7] != y[7]);
            end
            OP_AND_IMMEDIATE: r = x & y;
            OP_OR_IMMEDIATE: r = x | y;
            OP_XOR_IMMEDIATE: r = x ^ y;
            OP_LOAD_ACCUMULATOR: r = y;
            default: p = x * y;
        endcase
        if (o != OP_LOAD_ACCUMULATOR && o != OP_MULTIPLY_IMMEDIATE) begin
            f[4] = r[7];
            f[2] = r == 8'h00;
        end
        return {p, f, r};
    endfunction : alu

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge ref_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        chk({fetch_addr, working_accumulator, status_flags}, {PC_RESET, ACC_RESET, FLAGS_RESET});
        ef = FLAGS_RESET;
        ep = 16'h0000;
        for (i = 0; i < 42; i++) begin
            a = (i < 7) ? 8'h80 : 8'($random(seed));
            k = (i < 7) ? 8'h80 : 8'($random(seed));
            op = ops[i % 7];
            run({OP_LOAD_ACCUMULATOR, a});
            chk({working_accumulator, status_flags}, {a, ef});
            {ep, ef, ea} = alu(op, a, k, ef, ep);
            run({op, k});
            chk({product, status_flags, working_accumulator},
                {ep, ef, ea});
        end
        pc = fetch_addr;
        run(16'hF0E5);
        chk({fetch_addr, working_accumulator}, {pc + PC_STEP, ea});
        bk = 4'($random(seed));
        run({OP_SET_BANK_IMMEDIATE, bk});
        chk({bank_select_register, status_flags}, {bk, ef});
        for (i = 0; i < 4; i++) begin
            k = (i == 0) ? 8'h80 : 8'($random(seed));
            off = {{12{k[7]}}, k, 1'b0};
            run({i[0] ? OP_OR_IMMEDIATE : OP_AND_IMMEDIATE, 7'h00, i[0]});
            pc = fetch_addr;
            run({OP_BRANCH_ON_ZERO_FLAG, k});
            chk(fetch_addr, {i[0] ? pc + PC_STEP : pc + PC_STEP + off});
            if (!i[0]) begin
                run({OP_LOAD_ACCUMULATOR, 8'h77});
                chk({fetch_addr, working_accumulator},
                    {pc + PC_STEP + off, 8'h00});
            end
        end
        ef[4] = 1'b0;
        ef[2] = 1'b0;
        for (i = 0; i < 2; i++) begin
            a = 8'($random(seed));
            run({OP_LOAD_ACCUMULATOR, a});
            pc = fetch_addr;
            tgt = 20'($random(seed));
            run({OP_CALL_FIRST, i[0], tgt[7:0]});
            chk({stack_push, stack_push_addr}, {1'b1, pc + PC_STEP_TWO});
            chk({accumulator_shadow, flags_shadow, bank_shadow},
                i[0] ? {a, ef, bk} : 17'h00000);
            run({OP_SECOND_WORD_NIBBLE, tgt[19:8]});
            chk({stack_push, fetch_addr}, {1'b0, tgt, 1'b0});
            return_stack_top = pc + PC_STEP_TWO;
            ea = 8'($random(seed));
            run({OP_RETURN_WITH_IMM, ea});
            chk({stack_pop, fetch_addr, working_accumulator, status_flags},
                {1'b1, pc + PC_STEP_TWO, ea, ef});
            run(16'h0E55);
            chk({stack_pop, working_accumulator}, {1'b0, ea});
        end
        eptr = 36'h000000000;
        for (i = 0; i < 4; i++) begin
            k = 8'($random(seed));
            a = 8'($random(seed));
            run({OP_LOAD_POINTER_FIRST, i[1:0], a[3:0]});
            run({OP_LOAD_POINTER_SECOND, k});
            if (i < 3) eptr[i*12 +: 12] = {a[3:0], k};
            chk(indirect_pointer, eptr);
        end
        tp = 21'h000000;
        for (i = 0; i < 8; i++) begin
            op = 8'((i + 2) % 4);
            arm_en = i[2];
            pa = (op == 8'h03) ? tp + TBL_STEP : tp;
            tp = (op[0]) ? tp + TBL_STEP : (op == 8'h02) ? tp - TBL_STEP : tp;
            run({i[2] ? OP_PROGRAM_MEMORY_WRITE : OP_PROGRAM_MEMORY_READ, op[1:0]});
            chk({pm_read, pm_write, pm_addr, program_memory_pointer},
                {~i[2], i[2], pa, tp});
            if (i[2]) chk({pm_wdata, pm_write_active}, {lt, 1'b1});
            run(16'h0E99);
            chk({working_accumulator, status_flags}, {ea, ef});
            if (!i[2]) lt = pa[7:0] ^ 8'h5A;
            chk(program_memory_latch, lt);
        end
        arm_en = 1'b0;
        chk(pm_write_active, 1'b1);
        for (i = 0; i < 10 && pm_write_active === 1'b1; i++) run(16'hFFFF);
        chk({pm_write_active, i < 10}, 2'b01);
        for (i = 0; i < 24; i++) begin
            {timer_zero_write, prescaler_assigned, port_target} = 3'($random(seed));
            port_pins = 8'($random(seed));
            port_latch = 8'($random(seed));
            #1;
            chk(rmw_source, port_target ? port_pins : port_latch);
            run(16'hFFFF);
            chk(prescaler_clear, timer_zero_write & prescaler_assigned);
        end
        complete_run();
    end
endmodule : literal_table_branch_call_decoder_tb
